// ==== dv/ext_phy_model.sv ====
module ext_phy_model (
  // link clocks
  output logic tx_clk,
  output logic rx_clk,
  // receive pins
  output ext_mii_pkg::nibble_t rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic col,
  output logic crs,
  // control and strap
  input wire logic go,
  input wire logic fault,
  input wire logic collide,
  input wire logic strap,
  output logic mdio_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  import ext_mii_pkg::*;
  initial tx_clk = 1'b0;
  initial rx_clk = 1'b0;
  initial rxd = 4'h0;
  initial rx_dv = 1'b0;
  initial rx_er = 1'b0;
  initial crs = 1'b0;
  always #62.5 tx_clk = ~tx_clk;
  always #62.5 rx_clk = ~rx_clk;
  always @(negedge rx_clk)
  begin
    rx_dv <= go;
    rxd <= go ? 4'h5 : ~rxd;
    rx_er <= go & fault;
    crs <= go;
  end
  assign col = collide;
  assign mdio_drv = strap;
endmodule // ext_phy_model

// ==== dv/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ext_mii_pkg::*;
  logic clk_sys = 1'b0, sys_rst = 1'b1, int_sel = 1'b0, mg_sel = 1'b0;
  logic tx_v = 1'b0, m_mdc = 1'b0, m_do = 1'b0, m_oe = 1'b0;
  logic go = 1'b0, strap = 1'b1, fault = 1'b0, collide = 1'b0;
  nibble_t m_txd = 4'h0;
  nibble_t txd, rxd, m_rxd;
  logic tx_clk, rx_clk, tx_en, rx_dv, rx_er, col, crs, mdc, mdio_o;
  logic mdio_oe, mdio_i, m_din, m_rdv, m_rer, m_col, m_crs;
  logic tx_rise, rx_rise, strap_q, phy_mdio;
  int bad_count = 0;
  int n_checks = 0;
  always #5 clk_sys = ~clk_sys;
  assign mdio_i = mdio_oe ? mdio_o : phy_mdio;
  ext_mii_port ext_mii_port_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .internal_phy_select(int_sel), .ext_mgmt_port_select(mg_sel),
    .mac_txd(m_txd), .mac_tx_valid(tx_v), .mac_mdc(m_mdc),
    .mac_mdio_out(m_do), .mac_mdio_oe(m_oe), .mac_mdio_in(m_din),
    .mac_rxd(m_rxd), .mac_rx_dv(m_rdv), .mac_rx_er(m_rer),
    .mac_col(m_col), .mac_crs(m_crs), .tx_clk_rise(tx_rise),
    .rx_clk_rise(rx_rise), .external_phy_present_strap(strap_q),
    .tx_clk(tx_clk), .rx_clk(rx_clk), .txd(txd), .tx_en(tx_en),
    .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .col(col), .crs(crs),
    .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe));
  ext_phy_model ext_phy_model_inst (.tx_clk(tx_clk), .rx_clk(rx_clk),
    .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .col(col), .crs(crs),
    .go(go), .fault(fault), .collide(collide), .strap(strap),
    .mdio_drv(phy_mdio));
  task automatic chk(input string nm, input logic [3:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo(input int i);
    if (i >= 200)
    begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic t_strap();
    chk("strap", strap_q, 4'h1);
    strap = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk("strap_held", strap_q, 4'h1);
    $display("strap test done");
  endtask
  task automatic t_mgmt();
    mg_sel = 1'b1;
    m_mdc = 1'b1;
    m_oe = 1'b1;
    m_do = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk("mdc", mdc, 4'h1);
    chk("mdio_oe", mdio_oe, 4'h1);
    chk("mdio_o", mdio_o, 4'h1);
    chk("mdio_in_drv", m_din, 4'h1);
    m_mdc = 1'b0;
    m_oe = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk("mdc_low", mdc, 4'h0);
    chk("mdio_rel", mdio_oe, 4'h0);
    chk("mdio_in_phy", m_din, 4'h0);
    strap = 1'b1;
    m_mdc = 1'b1;
    m_oe = 1'b1;
    mg_sel = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk("mdc_off", mdc, 4'h0);
    chk("mdio_oe_off", mdio_oe, 4'h0);
    chk("mdio_in_off", m_din, 4'h0);
    $display("mgmt test done");
  endtask
  task automatic t_tx();
    int i;
    m_txd = 4'hA;
    tx_v = 1'b1;
    for (i = 0; i < 200 && !tx_rise; i++) @(negedge clk_sys);
    tmo(i);
    @(negedge clk_sys);
    chk("txd", txd, 4'hA);
    chk("tx_en", tx_en, 4'h1);
    chk("tx_rise_pulse", tx_rise, 4'h0);
    m_txd = 4'h5;
    tx_v = 1'b0;
    for (i = 0; i < 200 && !tx_rise; i++) @(negedge clk_sys);
    tmo(i);
    @(negedge clk_sys);
    chk("txd_idle", txd, 4'h0);
    chk("tx_en_idle", tx_en, 4'h0);
    m_txd = 4'hA;
    tx_v = 1'b1;
    int_sel = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk("txd_int", txd, 4'h0);
    chk("tx_en_int", tx_en, 4'h0);
    $display("tx test done");
  endtask
  task automatic t_rx();
    int i;
    go = 1'b1;
    for (i = 0; i < 200 && !m_rdv; i++) @(negedge clk_sys);
    tmo(i);
    chk("rxd", m_rxd, 4'h5);
    chk("rx_er", m_rer, 4'h0);
    chk("rx_rise", rx_rise, 4'h1);
    @(negedge clk_sys);
    chk("rx_rise_pulse", rx_rise, 4'h0);
    chk("crs", m_crs, 4'h1);
    chk("col", m_col, 4'h0);
    fault = 1'b1;
    for (i = 0; i < 200 && !m_rer; i++) @(negedge clk_sys);
    tmo(i);
    chk("rx_er_on", m_rer, 4'h1);
    chk("rxd_err", m_rxd, 4'h5);
    collide = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk("col_on", m_col, 4'h1);
    fault = 1'b0;
    collide = 1'b0;
    go = 1'b0;
    for (i = 0; i < 200 && m_rdv; i++) @(negedge clk_sys);
    tmo(i);
    chk("rx_dv_off", m_rdv, 4'h0);
    chk("rx_er_off", m_rer, 4'h0);
    repeat (5) @(negedge clk_sys);
    chk("crs_off", m_crs, 4'h0);
    chk("col_off", m_col, 4'h0);
    $display("rx test done");
  endtask
  task automatic t_reset();
    strap = 1'b0;
    sys_rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("strap_rst", strap_q, 4'h0);
    chk("tx_en_rst", tx_en, 4'h0);
    chk("mdc_rst", mdc, 4'h0);
    sys_rst = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk("strap_zero", strap_q, 4'h0);
    strap = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk("strap_zero_held", strap_q, 4'h0);
    $display("reset test done");
  endtask
  initial
  begin
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (6) @(negedge clk_sys);
    t_strap();
    t_mgmt();
    t_tx();
    t_rx();
    t_reset();
    give_verdict();
  end
endmodule // tb_top

// ==== rtl/ext_mii_params.svh ====
`ifndef EXT_MII_PARAMS_SVH
`define EXT_MII_PARAMS_SVH
`define NIBBLE_W 4
`define NIBBLE_ZERO 4'h0
`define STRAP_HOLD_CYC 2
`endif

// ==== rtl/ext_mii_pkg.sv ====
`include "ext_mii_params.svh"
package ext_mii_pkg;
  typedef logic [`NIBBLE_W-1:0] nibble_t;
endpackage

// ==== rtl/ext_mii_port.sv ====
`include "ext_mii_params.svh"
module ext_mii_port (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // configuration
  input wire logic internal_phy_select,
  input wire logic ext_mgmt_port_select,
  // mac transmit side
  input wire ext_mii_pkg::nibble_t mac_txd,
  input wire logic mac_tx_valid,
  // mac management side
  input wire logic mac_mdc,
  input wire logic mac_mdio_out,
  input wire logic mac_mdio_oe,
  output logic mac_mdio_in,
  // mac receive side, link clock edge pulses and strap
  output ext_mii_pkg::nibble_t mac_rxd,
  output logic mac_rx_dv,
  output logic mac_rx_er,
  output logic mac_col,
  output logic mac_crs,
  output logic tx_clk_rise,
  output logic rx_clk_rise,
  output logic external_phy_present_strap,
  // mii pins
  input wire logic tx_clk,
  input wire logic rx_clk,
  output ext_mii_pkg::nibble_t txd,
  output logic tx_en,
  input wire ext_mii_pkg::nibble_t rxd,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic col,
  input wire logic crs,
  // management pins
  output logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe
);
  import ext_mii_pkg::*;

  logic [10:0] sync_out;
  logic txc_q_r;
  logic rxc_q_r;
  logic [1:0] strap_cnt_r;
  logic strap_done_r;

  // rising edge of a sampled link clock
  function automatic logic rose_now(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // two-flop sampling of every pin input
  pin_sync #(.W(11)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_in({tx_clk, rx_clk, rxd, rx_dv, rx_er, col, crs, mdio_i}),
    .pin_out(sync_out)
  );

  // link clock edge detection
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      txc_q_r <= 1'b0;
      rxc_q_r <= 1'b0;
      tx_clk_rise <= 1'b0;
      rx_clk_rise <= 1'b0;
    end
    else
    begin
      txc_q_r <= sync_out[10];
      rxc_q_r <= sync_out[9];
      tx_clk_rise <= rose_now(sync_out[10], txc_q_r);
      rx_clk_rise <= rose_now(sync_out[9], rxc_q_r);
    end
  end

  // transmit: launch on tx clock edge
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      txd <= `NIBBLE_ZERO;
      tx_en <= 1'b0;
    end
    else if (internal_phy_select)
    begin
      txd <= `NIBBLE_ZERO;
      tx_en <= 1'b0;
    end
    else if (tx_clk_rise)
    begin
      txd <= mac_tx_valid ? mac_txd : `NIBBLE_ZERO;
      tx_en <= mac_tx_valid;
    end
  end

  // receive: capture on rx clock edge
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mac_rxd <= `NIBBLE_ZERO;
      mac_rx_dv <= 1'b0;
      mac_rx_er <= 1'b0;
    end
    else if (rose_now(sync_out[9], rxc_q_r))
    begin
      mac_rxd <= sync_out[8:5];
      mac_rx_dv <= sync_out[4];
      mac_rx_er <= sync_out[3];
    end
  end

  // carrier and collision are asynchronous levels
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mac_col <= 1'b0;
      mac_crs <= 1'b0;
    end
    else
    begin
      mac_col <= sync_out[2];
      mac_crs <= sync_out[1];
    end
  end

  // management pins
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mdc <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
      mac_mdio_in <= 1'b0;
    end
    else if (ext_mgmt_port_select)
    begin
      mdc <= mac_mdc;
      mdio_o <= mac_mdio_out;
      mdio_oe <= mac_mdio_oe;
      mac_mdio_in <= sync_out[0];
    end
    else
    begin
      mdc <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
      mac_mdio_in <= 1'b0;
    end
  end

  // strap capture after reset release
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
      external_phy_present_strap <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      if (strap_cnt_r == 2'(`STRAP_HOLD_CYC))
      begin
        external_phy_present_strap <= sync_out[0];
        strap_done_r <= 1'b1;
      end
      else
        strap_cnt_r <= strap_cnt_r + 2'h1;
    end
  end

  a_int_tx_zero: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    $past(internal_phy_select) |-> (txd == 4'h0 && !tx_en))
    else $error("tx pins not low with internal phy");
  a_tx_en_edge: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    $rose(tx_en) |-> $past(mac_tx_valid) && $past(tx_clk_rise))
    else $error("tx_en rose without valid nibble on edge");
  a_tx_hold: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    !$past(tx_clk_rise) && !$past(internal_phy_select) |-> $stable(txd))
    else $error("txd changed off edge");
  a_mdc_low_idle: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    !$past(ext_mgmt_port_select) |-> !mdc && !mdio_oe)
    else $error("mgmt pins active while deselected");
  a_mdc_follow: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    $past(ext_mgmt_port_select) |-> mdc == $past(mac_mdc))
    else $error("mdc not following mac clock");
  a_strap_stable: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    $past(strap_done_r) |-> $stable(external_phy_present_strap))
    else $error("strap changed after capture");
  a_strap_done: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    $rose(strap_done_r) |-> external_phy_present_strap == $past(sync_out[0]))
    else $error("strap captured wrong value");
  a_col_follow: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    col ##1 col ##1 col |-> ##1 mac_col)
    else $error("col not propagated");
  a_crs_follow: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    crs ##1 crs ##1 crs |-> ##1 mac_crs)
    else $error("crs not propagated");
  a_rx_capture: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    $rose(rx_clk_rise) |-> mac_rxd == $past(sync_out[8:5])
    && mac_rx_dv == $past(sync_out[4]))
    else $error("rx nibble not captured on rx edge");
  a_rx_err_pass: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    $rose(rx_clk_rise) |-> mac_rx_er == $past(sync_out[3]))
    else $error("rx error not captured on rx edge");
  a_rx_hold: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    !$rose(rx_clk_rise) |-> $stable(mac_rxd) && $stable(mac_rx_dv))
    else $error("rx outputs changed off edge");
  a_tx_rise_pulse: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    tx_clk_rise |=> !tx_clk_rise)
    else $error("tx edge pulse longer than one cycle");
  a_rx_rise_pulse: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    rx_clk_rise |=> !rx_clk_rise)
    else $error("rx edge pulse longer than one cycle");
  a_mdio_in_gate: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    !$past(ext_mgmt_port_select) |-> !mac_mdio_in)
    else $error("mdio input passed while deselected");
endmodule // ext_mii_port

// ==== rtl/pin_sync.sv ====
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // pins
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_r <= '0;
      pin_out <= '0;
    end
    else
    begin
      meta_r <= pin_in;
      pin_out <= meta_r;
    end
  end
endmodule // pin_sync
